// ---- hw/sso_pkg.sv ----
// Shared constants and types for the servo status output logic
package sso_pkg;

	// Control modes reported by the drive core
	typedef enum logic [2:0] {
		SSO_MODE_PULSE = 3'b000,	// Pulse-train position
		SSO_MODE_REG   = 3'b001,	// Internal-register position
		SSO_MODE_S     = 3'b010,	// Speed
		SSO_MODE_T     = 3'b011,	// Torque
		SSO_MODE_SZ    = 3'b100,	// Speed, zero reference
		SSO_MODE_TZ    = 3'b101	// Torque, zero reference
	} sso_mode_t;

	// Output function codes
	localparam logic [7:0] FN_IN_POSITION  = 8'h05;
	localparam logic [7:0] FN_TORQUE_LIMIT = 8'h06;
	localparam logic [7:0] FN_ALARM        = 8'h07;
	localparam logic [7:0] FN_BRAKE        = 8'h08;
	localparam logic [7:0] FN_HOMING_DONE  = 8'h09;
	localparam logic [7:0] FN_PRE_OVERLOAD = 8'h10;
	localparam logic [7:0] FN_WARNING      = 8'h11;

	// Origin sensor input function code, for reference
	localparam logic [7:0] FN_IN_ORIGIN    = 8'h24;

	// Overload alarm code shown when the full overload time elapses
	localparam logic [7:0] OVERLOAD_ALARM_CODE = 8'h06;

	// Timing: one millisecond base tick from the 8 ns core clock
	localparam int CLK_PERIOD_NS  = 8;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// Percent scale of the overload warning parameter
	localparam logic [7:0] PERCENT_FULL = 8'h64;

	// Brake sequencer states
	typedef enum logic [1:0] {
		BRK_RELEASED = 2'b00,
		BRK_WAIT_ON  = 2'b01,
		BRK_ENGAGED  = 2'b10,
		BRK_WAIT_OFF = 2'b11
	} sso_brake_t;

	// Reset values
	localparam logic RST_FLAG = 1'b0;
	localparam logic [7:0] NO_ALARM_CODE = 8'h00;	// No alarm latched

endpackage

// ---- hw/sso_overload_timer.sv ----
// Continuous overload timer with pre-overload and trip comparisons
`timescale 1ns/100ps
module sso_overload_timer #(
	parameter int ACC_W = 24	// Millisecond accumulator width
) (
	input  wire logic        i_core_clk,	// Core clock
	input  wire logic        i_rst_n,		// Async reset, active low
	input  wire logic        i_tick_ms,		// One-cycle millisecond tick
	input  wire logic        i_overload,	// Drive currently overloaded
	input  wire logic [15:0] i_limit_ms,	// Permissible overload time
	input  wire logic [7:0]  i_warn_pct,	// Overload warning percent
	output logic             o_pre_trip,	// Warning threshold passed
	output logic             o_trip		// Full overload time passed
);

	logic [ACC_W-1:0] acc_q;
	logic [31:0]      acc_scaled;
	logic [31:0]      thresh_scaled;

	// Accumulate only while continuously overloaded; saturate at top
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc_q <= '0;
		end else if (!i_overload) begin
			acc_q <= '0;
		end else if (i_tick_ms && !(&acc_q)) begin
			acc_q <= acc_q + 1'b1;
		end
	end

	// Scale the count by 100 and the limit by the percent so no divider is needed
	assign acc_scaled    = 32'(acc_q) * 32'(sso_pkg::PERCENT_FULL);
	assign thresh_scaled = 32'(i_limit_ms) * 32'(i_warn_pct);

	// Comparison results, registered
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pre_trip <= sso_pkg::RST_FLAG;
			o_trip     <= sso_pkg::RST_FLAG;
		end else begin
			o_pre_trip <= i_overload && (acc_scaled > thresh_scaled);
			o_trip     <= i_overload && (32'(acc_q) > 32'(i_limit_ms));
		end
	end

	acc_clear_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		!i_overload |=> (acc_q == '0) && !o_pre_trip && !o_trip)
		else $error("overload time not cleared");

	pre_trip_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_overload && acc_scaled > thresh_scaled) |=> o_pre_trip)
		else $error("pre-overload missed");

	trip_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		o_trip |-> $past(32'(acc_q) > 32'(i_limit_ms)))
		else $error("overload trip without cause");

endmodule

// ---- hw/sso_status_out.sv ----
// Servo drive status flags and digital output routing
`timescale 1ns/100ps
module sso_status_out #(
	parameter int NUM_DO      = 5,	// Physical digital outputs
	parameter int P_TICK_CYCLES = sso_pkg::TICK_CYCLES	// Clocks per ms
) (
	input  wire logic               i_core_clk,	// 125 MHz core clock
	input  wire logic               i_rst_n,	// Async reset, active low
	input  wire sso_pkg::sso_mode_t i_ctrl_mode,	// Active control mode
	input  wire logic signed [31:0] i_pos_err,	// Pulse-train position error
	input  wire logic signed [31:0] i_motor_pos,	// Motor position
	input  wire logic signed [31:0] i_target_pos,	// Register-mode target
	input  wire logic [15:0]        i_in_position_window,	// Window
	input  wire logic               i_torque_at_param_limit,	// Param limit
	input  wire logic               i_torque_at_analog_limit,	// Analog
	input  wire logic               i_alarm_cond,	// Other alarm detected
	input  wire logic [4:0]         i_warn_cond,	// Limits, stop, comm, UV
	input  wire logic               i_alarm_clear,	// Clear latched alarm
	input  wire logic               i_brake_request,	// Engage brake
	input  wire logic [15:0]        i_brake_on_delay,	// ms before engage
	input  wire logic [15:0]        i_brake_off_delay,	// ms before release
	input  wire logic               i_homing_start,	// Homing command pulse
	input  wire logic               i_origin_sensor_input,	// Origin sensor
	input  wire logic               i_pos_overflow,	// Position overflow
	input  wire logic               i_overload,	// Drive overloaded
	input  wire logic [15:0]        i_overload_limit_ms,	// Permissible time
	input  wire logic [7:0]         i_overload_warning_percent,	// Percent
	input  wire logic [7:0]         i_do_func [NUM_DO],	// Code per output
	output logic                    o_in_position_flag,	// In position
	output logic                    o_torque_limit_reached_flag,	// At limit
	output logic                    o_alarm_flag,	// Any alarm
	output logic                    o_warn_flag,	// Warning
	output logic                    o_holding_brake_output,	// Brake on
	output logic                    o_homing_complete_flag,	// Homed
	output logic                    o_pre_overload_flag,	// Pre-overload
	output logic                    o_overload_alarm,	// Overload alarm
	output logic [7:0]              o_alarm_code,	// Latched alarm code
	output logic [NUM_DO-1:0]       o_do	// Routed outputs
);

	localparam int TICK_W = $clog2(P_TICK_CYCLES + 1);

	logic [TICK_W-1:0]      tick_cnt_q;
	logic                   tick_ms;
	logic signed [32:0]     err_cmd;
	logic signed [32:0]     err_tgt;
	logic [32:0]            abs_cmd;
	logic [32:0]            abs_tgt;
	logic [32:0]            window;
	logic                   warn_q;
	logic                   homing_active_q;
	logic                   pre_trip;
	logic                   trip;
	sso_pkg::sso_brake_t    brk_q;
	logic [15:0]            brk_cnt_q;

	// Millisecond base tick; one clock, so slow rates are enables
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_cnt_q <= '0;
		end else if (tick_ms) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end
	assign tick_ms = (tick_cnt_q == TICK_W'(P_TICK_CYCLES - 1));

	// Widen before negating so the most negative error cannot wrap
	assign err_cmd = 33'(i_pos_err);
	assign err_tgt = 33'(i_motor_pos) - 33'(i_target_pos);
	assign abs_cmd = err_cmd[32] ? 33'(-err_cmd) : 33'(err_cmd);
	assign abs_tgt = err_tgt[32] ? 33'(-err_tgt) : 33'(err_tgt);
	assign window = 33'(i_in_position_window);

	// Position and torque flags follow their conditions each cycle
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_in_position_flag          <= sso_pkg::RST_FLAG;
			o_torque_limit_reached_flag <= sso_pkg::RST_FLAG;
		end else begin
			o_in_position_flag <=
				(i_ctrl_mode == sso_pkg::SSO_MODE_PULSE && abs_cmd <= window)
				|| (i_ctrl_mode == sso_pkg::SSO_MODE_REG
				&& abs_tgt <= window);
			o_torque_limit_reached_flag <=
				(i_torque_at_param_limit || i_torque_at_analog_limit)
				&& i_ctrl_mode != sso_pkg::SSO_MODE_T
				&& i_ctrl_mode != sso_pkg::SSO_MODE_TZ;
		end
	end

	// Warning leads alarm by one clock for the listed conditions
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			warn_q       <= sso_pkg::RST_FLAG;
			o_alarm_flag <= sso_pkg::RST_FLAG;
		end else begin
			warn_q       <= |i_warn_cond;
			o_alarm_flag <= i_alarm_cond || warn_q || o_overload_alarm;
		end
	end
	assign o_warn_flag = warn_q;

	// Overload alarm latches until cleared; a new trip wins over clear
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_overload_alarm <= sso_pkg::RST_FLAG;
			o_alarm_code     <= sso_pkg::NO_ALARM_CODE;
		end else if (trip) begin
			o_overload_alarm <= 1'b1;
			o_alarm_code     <= sso_pkg::OVERLOAD_ALARM_CODE;
		end else if (i_alarm_clear) begin
			o_overload_alarm <= 1'b0;
			o_alarm_code     <= sso_pkg::NO_ALARM_CODE;
		end
	end

	// Overload timing; pre-overload only reported in register mode
	sso_overload_timer u_ovl (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_tick_ms  (tick_ms),
		.i_overload (i_overload),
		.i_limit_ms (i_overload_limit_ms),
		.i_warn_pct (i_overload_warning_percent),
		.o_pre_trip (pre_trip),
		.o_trip     (trip)
	);
	assign o_pre_overload_flag =
		pre_trip && i_ctrl_mode == sso_pkg::SSO_MODE_REG;

	// Homing: command clears, origin during homing in register mode sets, overflow clears
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			homing_active_q        <= 1'b0;
			o_homing_complete_flag <= sso_pkg::RST_FLAG;
		end else if (i_homing_start) begin
			homing_active_q        <= 1'b1;
			o_homing_complete_flag <= 1'b0;
		end else if (homing_active_q && i_origin_sensor_input
			&& i_ctrl_mode == sso_pkg::SSO_MODE_REG) begin
			homing_active_q        <= 1'b0;
			o_homing_complete_flag <= 1'b1;
		end else if (i_pos_overflow) begin
			o_homing_complete_flag <= 1'b0;
		end
	end

	// Brake sequencer counts delays in ms; request change aborts a wait
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			brk_q     <= sso_pkg::BRK_RELEASED;
			brk_cnt_q <= 16'h0000;
		end else begin
			unique case (brk_q)
				sso_pkg::BRK_RELEASED: begin
					brk_cnt_q <= 16'h0000;
					if (i_brake_request) begin
						brk_q <= sso_pkg::BRK_WAIT_ON;
					end
				end
				sso_pkg::BRK_WAIT_ON: begin
					if (!i_brake_request) begin
						brk_q <= sso_pkg::BRK_RELEASED;
					end else if (brk_cnt_q >= i_brake_on_delay) begin
						brk_q     <= sso_pkg::BRK_ENGAGED;
						brk_cnt_q <= 16'h0000;
					end else if (tick_ms) begin
						brk_cnt_q <= brk_cnt_q + 1'b1;
					end
				end
				sso_pkg::BRK_ENGAGED: begin
					brk_cnt_q <= 16'h0000;
					if (!i_brake_request) begin
						brk_q <= sso_pkg::BRK_WAIT_OFF;
					end
				end
				sso_pkg::BRK_WAIT_OFF: begin
					if (i_brake_request) begin
						brk_q     <= sso_pkg::BRK_ENGAGED;
						brk_cnt_q <= 16'h0000;
					end else if (brk_cnt_q >= i_brake_off_delay) begin
						brk_q     <= sso_pkg::BRK_RELEASED;
					end else if (tick_ms) begin
						brk_cnt_q <= brk_cnt_q + 1'b1;
					end
				end
			endcase
		end
	end
	assign o_holding_brake_output = (brk_q == sso_pkg::BRK_ENGAGED)
		|| (brk_q == sso_pkg::BRK_WAIT_OFF);

	// Route each physical output to its configured function
	for (genvar k = 0; k < NUM_DO; k++) begin : g_do
		always_ff @(posedge i_core_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				o_do[k] <= sso_pkg::RST_FLAG;
			end else begin
				unique case (i_do_func[k])
					sso_pkg::FN_IN_POSITION:  o_do[k] <= o_in_position_flag;
					sso_pkg::FN_TORQUE_LIMIT:
						o_do[k] <= o_torque_limit_reached_flag;
					sso_pkg::FN_ALARM:        o_do[k] <= o_alarm_flag;
					sso_pkg::FN_BRAKE:        o_do[k] <= o_holding_brake_output;
					sso_pkg::FN_HOMING_DONE:  o_do[k] <= o_homing_complete_flag;
					sso_pkg::FN_PRE_OVERLOAD: o_do[k] <= o_pre_overload_flag;
					sso_pkg::FN_WARNING:      o_do[k] <= o_warn_flag;
					default:                  o_do[k] <= 1'b0;
				endcase
			end
		end
	end

	in_pos_pulse_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_ctrl_mode == sso_pkg::SSO_MODE_PULSE) |=>
			(o_in_position_flag == ($past(abs_cmd) <= $past(window))))
		else $error("pulse-train in-position wrong");

	in_pos_reg_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_ctrl_mode == sso_pkg::SSO_MODE_REG) |=>
			(o_in_position_flag == ($past(abs_tgt) <= $past(window))))
		else $error("register-mode in-position wrong");

	torque_mode_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_ctrl_mode == sso_pkg::SSO_MODE_T
		|| i_ctrl_mode == sso_pkg::SSO_MODE_TZ) |=>
			!o_torque_limit_reached_flag)
		else $error("torque-limit flag in torque mode");

	alarm_any_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		i_alarm_cond |=> o_alarm_flag)
		else $error("alarm condition not flagged");

	warn_first_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(|i_warn_cond) |=> o_warn_flag ##1 o_alarm_flag)
		else $error("warning did not lead alarm");

	ovl_alarm_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		trip |=> o_overload_alarm ##1 o_alarm_flag)
		else $error("overload alarm not raised");

	brake_hold_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(o_holding_brake_output) |->
			$past(brk_cnt_q) >= $past(i_brake_on_delay))
		else $error("brake engaged before delay");

	home_clear_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		i_homing_start |=> !o_homing_complete_flag)
		else $error("homing command did not clear flag");

	home_keep_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		$fell(o_homing_complete_flag) |->
			$past(i_pos_overflow) || $past(i_homing_start))
		else $error("homing flag cleared without cause");

	home_set_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		$rose(o_homing_complete_flag) |->
			$past(homing_active_q) && $past(i_origin_sensor_input))
		else $error("homing flag set without origin");

	pre_ovl_mode_a: assert property (
		@(posedge i_core_clk) disable iff (!i_rst_n)
		o_pre_overload_flag |-> i_ctrl_mode == sso_pkg::SSO_MODE_REG)
		else $error("pre-overload outside register mode");

endmodule

// ---- dv/sso_ctrl_model.sv ----
// Machine controller model that samples the drive's digital outputs
`timescale 1ns/100ps
module sso_ctrl_model #(
	parameter int NUM_DO = 5	// Outputs wired to the controller
) (
	input  wire logic              i_core_clk,	// Sampling clock
	input  wire logic              i_rst_n,	// Reset, active low
	input  wire logic [NUM_DO-1:0] i_do,	// Drive digital outputs
	output logic      [NUM_DO-1:0] o_seen,	// Last sampled outputs
	output logic      [15:0]       o_edges	// Output changes seen
);
	// Input card samples on the rising edge, one cycle behind the pins
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_seen  <= '0;
			o_edges <= '0;
		end else begin
			o_seen <= i_do;
			if (i_do != o_seen) begin
				o_edges <= o_edges + 16'h0001;
			end
		end
	end
endmodule

// ---- dv/servo_status_output_logic_bench.sv ----
// Self-checking bench for the servo status output logic
`timescale 1ns/100ps
module servo_status_output_logic_bench;
	logic               clk, rst_n, tq_p, tq_a, alm, aclr, breq;
	logic               hstart, orig, ovf, ovl;
	sso_pkg::sso_mode_t mode;
	logic signed [31:0] perr, mpos, in_position_flag;
	logic [15:0]        win, bon, boff, olim;
	logic [4:0]         wcond, dout, seen, ev, prev;
	logic [7:0]         wpct, acode;
	logic [7:0]         dofn [5];
	logic [15:0]        edges;
	logic               inpos, torq_o, alarm_o, warn, brake, homed, preol, olalm;
	int                 mismatches, checks_done, n, d, ex, n_chg;
	int                 cor [4] = '{16, -16, 17, -17};
	logic [7:0]         codes [9] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
		8'h10, 8'h11, 8'h00, 8'h2a};

	sso_status_out #(.NUM_DO(5), .P_TICK_CYCLES(10)) i_sso_status_out (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_ctrl_mode(mode),
		.i_pos_err(perr), .i_motor_pos(mpos), .i_target_pos(in_position_flag),
		.i_in_position_window(win), .i_torque_at_param_limit(tq_p),
		.i_torque_at_analog_limit(tq_a), .i_alarm_cond(alm),
		.i_warn_cond(wcond), .i_alarm_clear(aclr), .i_brake_request(breq),
		.i_brake_on_delay(bon), .i_brake_off_delay(boff),
		.i_homing_start(hstart), .i_origin_sensor_input(orig),
		.i_pos_overflow(ovf), .i_overload(ovl), .i_overload_limit_ms(olim),
		.i_overload_warning_percent(wpct), .i_do_func(dofn),
		.o_in_position_flag(inpos), .o_torque_limit_reached_flag(torq_o),
		.o_alarm_flag(alarm_o), .o_warn_flag(warn),
		.o_holding_brake_output(brake), .o_homing_complete_flag(homed),
		.o_pre_overload_flag(preol), .o_overload_alarm(olalm),
		.o_alarm_code(acode), .o_do(dout));

	sso_ctrl_model #(.NUM_DO(5)) i_sso_ctrl_model (.i_core_clk(clk),
		.i_rst_n(rst_n), .i_do(dout), .o_seen(seen), .o_edges(edges));

	// Free-running 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic wrap_up();
		if (mismatches == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: return brake;
			1: return preol;
			default: return olalm;
		endcase
	endfunction

	// Bounded wait; a stuck flag ends the run rather than hanging it
	task automatic wait_for(input int w, input logic v, output int k);
		k = 0;
		while (pick(w) !== v) begin
			@(negedge clk);
			k++;
			if (k > 400) begin
				mismatches++;
				wrap_up();
			end
		end
	endtask

	// Flags held by the routing scenario: in position, alarm, homed
	function automatic logic exp_fn(input logic [7:0] c);
		return c == 8'h05 || c == 8'h07 || c == 8'h09;
	endfunction

	// Watchdog on the whole run
	initial begin
		repeat (100000) @(posedge clk);
		mismatches++;
		wrap_up();
	end

	// Main sequence, all inputs changed on the falling edge
	initial begin
		{rst_n, tq_p, tq_a, alm, aclr, breq, hstart, orig, ovf, ovl} = '0;
		mode = sso_pkg::SSO_MODE_PULSE;
		{perr, mpos, in_position_flag, wcond} = '0;
		win = 16'h0010; bon = 16'h0003; boff = 16'h0002;
		olim = 16'h000a; wpct = 8'h3c;
		foreach (dofn[k]) dofn[k] = 8'h00;
		void'($urandom(32'h4e9b));
		repeat (3) @(posedge clk);
		chk(homed, 1'b0);
		@(negedge clk) rst_n = 1'b1;
		chk({inpos, torq_o, alarm_o, warn, brake, homed, preol, dout}, '0);
		// Position window in both position modes, ignored in speed mode
		for (int i = 0; i < 60; i++) begin
			d = (i < 4) ? cor[i] : int'($urandom_range(40)) - 20;
			mode = sso_pkg::sso_mode_t'(i % 3);
			in_position_flag = $urandom_range(100000);
			mpos = (i % 3 == 0) ? in_position_flag : in_position_flag + d;
			perr = (i % 3 == 1) ? 32'h7fff0000 : d;
			ex = (i % 3 != 2) && d <= 16 && d >= -16;
			@(negedge clk);
			chk(inpos, ex[0]);
		end
		// Torque limit from either source, not in torque modes
		for (int m = 0; m < 6; m++)
			for (int k = 0; k < 4; k++) begin
				mode = sso_pkg::sso_mode_t'(m);
				{tq_p, tq_a} = k[1:0];
				@(negedge clk);
				chk(torq_o, k != 0 && m != 3 && m != 5);
			end
		{tq_p, tq_a} = 2'b00;
		// Plain alarm, then each warning cause ahead of the alarm
		alm = 1'b1;
		@(negedge clk) alm = 1'b0;
		chk(alarm_o, 1'b1);
		@(negedge clk) chk(alarm_o, 1'b0);
		for (int b = 0; b < 5; b++) begin
			mode = sso_pkg::sso_mode_t'(b);
			wcond = 5'h01 << b;
			@(negedge clk) chk({warn, alarm_o}, 2'b10);
			@(negedge clk) chk(alarm_o, 1'b1);
			wcond = 5'h00;
			cyc(3);
		end
		// Brake engage and release delays in ms ticks
		breq = 1'b1;
		wait_for(0, 1'b1, n);
		chk(n >= 18 && n <= 34, 1'b1);
		breq = 1'b0;
		wait_for(0, 1'b0, n);
		chk(n >= 8 && n <= 24, 1'b1);
		// Homing: set by origin, held while running, cleared by overflow
		mode = sso_pkg::SSO_MODE_REG;
		hstart = 1'b1;
		@(negedge clk) hstart = 1'b0;
		chk(homed, 1'b0);
		orig = 1'b1;
		@(negedge clk) orig = 1'b0;
		chk(homed, 1'b1);
		mode = sso_pkg::SSO_MODE_S;
		cyc(5);
		chk(homed, 1'b1);
		ovf = 1'b1;
		@(negedge clk) ovf = 1'b0;
		chk(homed, 1'b0);
		hstart = 1'b1;
		@(negedge clk) hstart = 1'b0;
		orig = 1'b1;
		cyc(2);
		chk(homed, 1'b0);
		mode = sso_pkg::SSO_MODE_REG;
		cyc(2);
		chk(homed, 1'b1);
		orig = 1'b0;
		hstart = 1'b1;
		@(negedge clk) hstart = 1'b0;
		chk(homed, 1'b0);
		orig = 1'b1;
		@(negedge clk) orig = 1'b0;
		chk(homed, 1'b1);
		// Routing of random function codes to the outputs
		mode = sso_pkg::SSO_MODE_PULSE;
		perr = 0;
		alm = 1'b1;
		// Settle the flags first so each new setting moves the pins once
		cyc(2);
		prev = '0;
		n_chg = 0;
		for (int i = 0; i < 12; i++) begin
			foreach (dofn[k]) begin
				dofn[k] = codes[$urandom_range(8)];
				ev[k] = exp_fn(dofn[k]);
			end
			// One controller-side edge per changed output pattern
			if (ev != prev) begin
				n_chg++;
			end
			prev = ev;
			cyc(4);
			chk(dout, ev);
			chk(seen, ev);
		end
		chk(edges, n_chg);
		alm = 1'b0;
		// Overload: a break restarts the count, then warning and trip
		mode = sso_pkg::SSO_MODE_REG;
		ovl = 1'b1;
		cyc(50);
		ovl = 1'b0;
		cyc(2);
		chk(preol, 1'b0);
		ovl = 1'b1;
		wait_for(1, 1'b1, n);
		chk(n >= 58 && n <= 75, 1'b1);
		chk(olalm, 1'b0);
		mode = sso_pkg::SSO_MODE_PULSE;
		@(negedge clk) chk(preol, 1'b0);
		mode = sso_pkg::SSO_MODE_REG;
		wait_for(2, 1'b1, n);
		chk(n >= 33 && n <= 46, 1'b1);
		@(negedge clk) chk({alarm_o, acode},
			{1'b1, sso_pkg::OVERLOAD_ALARM_CODE});
		ovl = 1'b0;
		cyc(2);
		chk({preol, olalm}, 2'b01);
		aclr = 1'b1;
		@(negedge clk) aclr = 1'b0;
		cyc(2);
		chk({olalm, alarm_o}, 2'b00);
		wrap_up();
	end
endmodule
